/* fepic_pkg.sv */
// Purpose: Constants, types and reset values for the flash erase, deep
//          sleep and identification command block.
// Assumes: Core clock of 40 MHz; serial clock idle while select is high.
// Notes:   Identity bytes are parameters of the top module.

package fepic_pkg;

   // ---------------------------------------------------------------
   // Opcodes
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
   localparam logic [7:0] OP_ERASE_A = 8'hc7;
   localparam logic [7:0] OP_ERASE_B = 8'h60;
   localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
   localparam logic [7:0] OP_WAKE_ID = 8'hab;
   localparam logic [7:0] OP_MAKER_DEV = 8'h90;
   localparam logic [7:0] OP_STD_ID = 8'h9f;

   // ---------------------------------------------------------------
   // Frame bit positions
   // ---------------------------------------------------------------
   localparam logic [5:0] OPCODE_BITS = 6'h08;
   localparam logic [5:0] ADDR_END_BITS = 6'h20;
   localparam logic [5:0] BITS_MAX = 6'h3f;
   localparam logic [4:0] LAST_POS_ONE = 5'h07;
   localparam logic [4:0] LAST_POS_TWO = 5'h0f;
   localparam logic [4:0] LAST_POS_THREE = 5'h17;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int SLEEP_ENTRY_NS = 3000;
   localparam int RELEASE_FIRST_NS = 3000;
   localparam int RELEASE_SECOND_NS = 1800;
   localparam logic [23:0] SLEEP_ENTRY_CYC =
      24'((SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [23:0] RELEASE_FIRST_CYC =
      24'((RELEASE_FIRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [23:0] RELEASE_SECOND_CYC =
      24'(RELEASE_SECOND_NS / CLK_PERIOD_NS);
   localparam logic [23:0] TIMER_ONE = 24'h000001;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_ERASING,
      ST_ENTERING,
      ST_SLEEPING,
      ST_WAKING
   } fepic_state_type;

   // Rising-edge link state
   typedef struct packed
   {
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [5:0] bits;
      logic busy_meta;
      logic busy_sync;
      logic sleep_meta;
      logic sleep_sync;
   } fepic_link_type;

   // Falling-edge output state
   typedef struct packed
   {
      logic bit_val;
      logic oe;
      logic [4:0] pos;
   } fepic_drive_type;

   // Core clock state
   typedef struct packed
   {
      logic cs_meta;
      logic cs_sync;
      logic cs_prev;
      fepic_state_type state;
      logic [23:0] timer;
      logic pending;
      logic latch;
      logic asleep;
      logic standby;
   } fepic_core_type;

   localparam fepic_core_type CORE_RESET = '{
      cs_meta: 1'b1, cs_sync: 1'b1, cs_prev: 1'b1, state: ST_IDLE,
      timer: 24'h000000, pending: 1'b0, latch: 1'b0, asleep: 1'b0,
      standby: 1'b0};

endpackage

/* fepic_top.sv */
// Purpose: Serial command handling for full-array erase, deep sleep and
//          identification reads inside the flash device.
// Assumes: Serial clock stands still while select is high.
// Notes:   Link logic runs on the serial clock; status lives on clk_in.
`timescale 1ns/1ps

module fepic_top
#(
   parameter int ERASE_CYCLES = 1000000,
   parameter logic [7:0] MAKER_CODE = 8'h5a,   // Arbitrary value
   parameter logic [7:0] DEVICE_CODE = 8'h15,  // Arbitrary value
   parameter logic [7:0] MEM_TYPE = 8'h40,     // Arbitrary value
   parameter logic [7:0] CAPACITY = 8'h16      // Arbitrary value
)
(
   // Core clock and control
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // Serial link pins
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic serial_in,
   output logic serial_out_out,
   output logic serial_out_oe_out,
   // Neighbouring device logic
   input wire logic any_block_protected_in,
   input wire logic soft_reset_in,
   // Status
   output logic operation_pending_flag_out,
   output logic write_unlock_latch_out,
   output logic deep_sleep_out,
   output logic standby_out
);
   import fepic_pkg::*;

   fepic_link_type link;
   fepic_link_type next_link;
   fepic_drive_type drive;
   fepic_drive_type next_drive;
   fepic_core_type core;
   fepic_core_type next_core;
   logic fresh;
   logic [5:0] cnt;
   logic [5:0] start;
   logic [4:0] last;
   logic [7:0] out_byte;
   logic out_ok;
   logic cs_rise;
   logic exact;
   logic is_erase;

   // ---------------------------------------------------------------
   // Link side: rising edges
   // ---------------------------------------------------------------

   // Marks the first serial edge of each frame
   always_ff @(posedge sclk_in or posedge cs_n_in)
   begin
      if (cs_n_in)
         fresh <= 1'b1;
      else
         fresh <= 1'b0;
   end

   // Shift opcode then address; count frame bits
   always_comb
   begin
      next_link = link;
      cnt = fresh ? 6'h00 : link.bits;
      next_link.busy_meta = core.pending;
      next_link.busy_sync = link.busy_meta;
      next_link.sleep_meta = core.asleep;
      next_link.sleep_sync = link.sleep_meta;
      if (cnt < OPCODE_BITS)
         next_link.opcode = {link.opcode[6:0], serial_in};
      else if (cnt < ADDR_END_BITS)
         next_link.addr = {link.addr[22:0], serial_in};
      next_link.bits = (cnt == BITS_MAX) ? BITS_MAX : cnt + 6'h01;
   end

   // Link rising-edge register
   always_ff @(posedge sclk_in)
   begin
      link <= next_link;
   end

   // ---------------------------------------------------------------
   // Link side: falling edges, identity output
   // ---------------------------------------------------------------

   // Pick source byte and gating per opcode
   always_comb
   begin
      start = ADDR_END_BITS;
      last = LAST_POS_ONE;
      out_byte = DEVICE_CODE;
      out_ok = 1'b0;
      unique case (link.opcode)
         OP_WAKE_ID:
         begin
            out_ok = !link.busy_sync;
         end
         OP_MAKER_DEV:
         begin
            last = LAST_POS_TWO;
            out_ok = !link.busy_sync && !link.sleep_sync;
            if (drive.pos[3] ^ link.addr[0])
               out_byte = DEVICE_CODE;
            else
               out_byte = MAKER_CODE;
         end
         OP_STD_ID:
         begin
            start = OPCODE_BITS;
            last = LAST_POS_THREE;
            out_ok = !link.busy_sync && !link.sleep_sync;
            unique case (drive.pos[4:3])
               2'h0: out_byte = MAKER_CODE;
               2'h1: out_byte = MEM_TYPE;
               default: out_byte = CAPACITY;
            endcase
         end
         default:
         begin
            out_ok = 1'b0;
         end
      endcase
      next_drive = drive;
      if (out_ok && !fresh && link.bits >= start)
      begin
         next_drive.oe = 1'b1;
         next_drive.bit_val = out_byte[3'h7 - drive.pos[2:0]];
         next_drive.pos = (drive.pos == last) ? 5'h00 : drive.pos + 5'h01;
      end
   end

   // Output register; select high stops output at once
   always_ff @(negedge sclk_in or posedge cs_n_in)
   begin
      if (cs_n_in)
         drive <= '0;
      else
         drive <= next_drive;
   end

   assign serial_out_out = drive.bit_val;
   assign serial_out_oe_out = drive.oe;

   // ---------------------------------------------------------------
   // Core side: frame decode and self-timed cycles
   // ---------------------------------------------------------------

   assign cs_rise = core.cs_sync && !core.cs_prev;
   assign exact = (link.bits == OPCODE_BITS);
   assign is_erase = (link.opcode == OP_ERASE_A) ||
      (link.opcode == OP_ERASE_B);

   // Next core state
   always_comb
   begin
      next_core = core;
      next_core.cs_meta = cs_n_in;
      next_core.cs_sync = core.cs_meta;
      next_core.cs_prev = core.cs_sync;
      next_core.standby = core.cs_sync && (core.state == ST_IDLE);
      unique case (core.state)
         ST_IDLE:
         begin
            if (cs_rise && exact)
            begin
               if (link.opcode == OP_WRITE_UNLOCK)
                  next_core.latch = 1'b1;
               else if (is_erase && core.latch &&
                  !any_block_protected_in)
               begin
                  next_core.state = ST_ERASING;
                  next_core.pending = 1'b1;
                  next_core.latch = 1'b0;
                  next_core.timer = 24'(ERASE_CYCLES);
               end
               else if (link.opcode == OP_DEEP_SLEEP)
               begin
                  next_core.state = ST_ENTERING;
                  next_core.timer = SLEEP_ENTRY_CYC;
               end
            end
         end
         ST_ERASING:
         begin
            // Frames ignored while erasing
            next_core.timer = core.timer - TIMER_ONE;
            if (core.timer == TIMER_ONE)
            begin
               next_core.state = ST_IDLE;
               next_core.pending = 1'b0;
            end
         end
         ST_ENTERING:
         begin
            next_core.timer = core.timer - TIMER_ONE;
            if (core.timer == TIMER_ONE)
            begin
               next_core.state = ST_SLEEPING;
               next_core.asleep = 1'b1;
            end
         end
         ST_SLEEPING:
         begin
            if (soft_reset_in)
            begin
               next_core.state = ST_IDLE;
               next_core.asleep = 1'b0;
            end
            else if (cs_rise && link.opcode == OP_WAKE_ID &&
               link.bits >= OPCODE_BITS)
            begin
               next_core.state = ST_WAKING;
               if (exact)
                  next_core.timer = RELEASE_FIRST_CYC;
               else
                  next_core.timer = RELEASE_SECOND_CYC;
            end
         end
         ST_WAKING:
         begin
            next_core.timer = core.timer - TIMER_ONE;
            if (core.timer == TIMER_ONE)
            begin
               next_core.state = ST_IDLE;
               next_core.asleep = 1'b0;
            end
         end
         default:
         begin
            next_core = CORE_RESET;
         end
      endcase
   end

   // Core register; reset loads idle with standby low, standby rises on the next enabled cycle
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
         core <= CORE_RESET;
      else if (ce_in)
         core <= next_core;
   end

   assign operation_pending_flag_out = core.pending;
   assign write_unlock_latch_out = core.latch;
   assign deep_sleep_out = core.asleep;
   assign standby_out = core.standby;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------

   AST_ERASE_NEEDS_LATCH: assert property (@(posedge clk_in)
      disable iff (!rst_n_in) $rose(core.pending) |-> $past(core.latch))
      else $error("Erase started without write-unlock latch");

   AST_ERASE_EXACT_BITS: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      $rose(core.pending) |-> $past(link.bits) == OPCODE_BITS)
      else $error("Erase started on a frame of wrong length");

   AST_ERASE_ENDS_ON_TIMER: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      $fell(core.pending) |-> $past(core.timer) == TIMER_ONE &&
      core.state == ST_IDLE)
      else $error("Pending flag fell before erase time ran out");

   AST_LATCH_CLEARED: assert property (@(posedge clk_in)
      disable iff (!rst_n_in) core.pending |-> !core.latch)
      else $error("Write-unlock latch still set during erase");

   AST_PROTECT_BLOCKS: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      $rose(core.pending) |-> !$past(any_block_protected_in))
      else $error("Erase started while a block was protected");

   AST_SLEEP_VIA_ENTRY: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      $rose(core.asleep) |-> $past(core.state) == ST_ENTERING &&
      $past(core.timer) == TIMER_ONE)
      else $error("Deep sleep entered without the entry delay");

   AST_STANDBY: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      ce_in && core.cs_sync && core.state == ST_IDLE |=> core.standby)
      else $error("Standby not shown while deselected and idle");

   AST_RESET_STANDBY: assert property (@(posedge clk_in)
      $rose(rst_n_in) |-> core.state == ST_IDLE && !core.asleep &&
      !core.pending)
      else $error("Device left reset outside ordinary standby");

   AST_NO_SLEEP_WHEN_BUSY: assert property (@(posedge clk_in)
      disable iff (!rst_n_in) core.pending |-> !core.asleep)
      else $error("Deep sleep reached during a running erase");

   AST_WAKE_LEAVES_SLEEP: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      $fell(core.asleep) |-> $past(core.state) == ST_WAKING ||
      $past(soft_reset_in))
      else $error("Deep sleep left without wake or reset");

   AST_NO_ID_WHEN_BUSY: assert property (@(negedge sclk_in)
      disable iff (cs_n_in) $rose(drive.oe) |-> !$past(link.busy_sync))
      else $error("Identity output started during a running cycle");

   AST_UNLOCK_EXACT: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      $rose(core.latch) |-> $past(link.bits) == OPCODE_BITS &&
      $past(link.opcode) == OP_WRITE_UNLOCK)
      else $error("Write-unlock latch set by a malformed frame");

   AST_SLEEP_NO_UNLOCK: assert property (@(posedge clk_in)
      disable iff (!rst_n_in) $rose(core.latch) |-> !$past(core.asleep))
      else $error("Write-unlock accepted during deep sleep");

   AST_ERASE_FROM_IDLE: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      $rose(core.pending) |-> $past(core.state) == ST_IDLE)
      else $error("Erase started outside the idle state");

   AST_SLEEP_CMD_EXACT: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      $rose(core.state == ST_ENTERING) |-> $past(core.state) == ST_IDLE &&
      $past(link.bits) == OPCODE_BITS &&
      $past(link.opcode) == OP_DEEP_SLEEP && core.timer == SLEEP_ENTRY_CYC)
      else $error("Deep-sleep entry began without an exact idle frame");

   AST_WAKE_FIRST_DELAY: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      $rose(core.state == ST_WAKING) && $past(link.bits) == OPCODE_BITS |->
      core.timer == RELEASE_FIRST_CYC)
      else $error("Plain wake did not load the first release delay");

   AST_WAKE_SECOND_DELAY: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      $rose(core.state == ST_WAKING) && $past(link.bits) > OPCODE_BITS |->
      core.timer == RELEASE_SECOND_CYC)
      else $error("Identity wake did not load the second release delay");

   AST_WAKE_NEEDS_OPCODE: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      $rose(core.state == ST_WAKING) |->
      $past(link.opcode) == OP_WAKE_ID && $past(core.asleep))
      else $error("Wake delay started without a wake opcode in sleep");

   AST_FRAME_STARTS_QUIET: assert property (@(posedge sclk_in)
      disable iff (cs_n_in) fresh |-> !drive.oe)
      else $error("Identity output still on at the start of a frame");

   AST_STD_ID_FIRST: assert property (@(negedge sclk_in)
      disable iff (cs_n_in)
      $rose(drive.oe) && link.opcode == OP_STD_ID |->
      link.bits == OPCODE_BITS + 6'h01 && drive.bit_val == MAKER_CODE[7])
      else $error("Standard identity output did not follow the opcode");

   AST_ADDR_ID_FIRST: assert property (@(negedge sclk_in)
      disable iff (cs_n_in)
      $rose(drive.oe) && link.opcode == OP_MAKER_DEV |->
      link.bits == ADDR_END_BITS + 6'h01)
      else $error("Maker and device output did not follow the address");

   AST_WAKE_ID_FIRST: assert property (@(negedge sclk_in)
      disable iff (cs_n_in)
      $rose(drive.oe) && link.opcode == OP_WAKE_ID |->
      link.bits == ADDR_END_BITS + 6'h01 && drive.bit_val == DEVICE_CODE[7])
      else $error("Device code output did not follow the dummy bytes");

   COV_ERASE: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      $rose(core.pending));
   COV_SLEEP: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      $rose(core.asleep));
   COV_WAKE: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      $fell(core.asleep));
   COV_ID_OUT: cover property (@(negedge sclk_in) disable iff (cs_n_in)
      $rose(drive.oe));

endmodule // fepic_top

/* fepic_host_model.sv */
// Purpose: Host serial controller that sends frames to the command block.
// Assumes: lclk_in is the free link clock; serial clock is gated from it.
// Notes:   Serial clock idles low and stands still between frames.
`timescale 1ns/1ps

module fepic_host_model
(
   // Link clock
   input wire logic lclk_in,
   // Serial pins
   output logic sclk_out,
   output logic cs_n_out,
   output logic mosi_out,
   input wire logic miso_in,
   input wire logic miso_oe_in
);
   logic oe_seen;

   // Idle pins; a first select rise clears the unreset output flops
   initial
   begin
      sclk_out = 1'b0;
      cs_n_out = 1'b0;
      mosi_out = 1'b0;
      oe_seen = 1'b0;
      #2 cs_n_out = 1'b1;
   end

   // One whole frame, n bits MSB first, reply bits gathered at each rise
   task automatic xfer(input logic [63:0] tx, input int n,
                       output logic [63:0] rx);
      rx = 64'h0;
      oe_seen = 1'b0;
      @(posedge lclk_in);
      #1 cs_n_out = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         @(posedge lclk_in);
         #1 sclk_out = 1'b0;
         mosi_out = tx[i];
         @(posedge lclk_in);
         #1 oe_seen = oe_seen | miso_oe_in;
         rx = {rx[62:0], miso_in};
         sclk_out = 1'b1;
      end
      @(posedge lclk_in);
      #1 sclk_out = 1'b0;
      @(posedge lclk_in);
      #1 cs_n_out = 1'b1;
      mosi_out = ~mosi_out;
   endtask
endmodule // fepic_host_model

/* fepic_tb.sv */
// Purpose: Self-checking bench for erase, deep sleep and identity reads.
// Assumes: Core clock 25 ns, link clock 6 ns, erase shortened to 200.
// Notes:   Host gaps cover the release and entry delays.
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
   begin \
      compares++; \
      if ((got) !== (exp)) \
      begin \
         failures++; \
         $display("[ERR] %s expected %h seen %h", nm, exp, got); \
      end \
   end

module tb;
   import fepic_pkg::*;
   localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
   localparam logic [7:0] DEV = 8'h15;   // Arbitrary value
   localparam logic [7:0] MEM = 8'h40;   // Arbitrary value
   localparam logic [7:0] CAP = 8'h16;   // Arbitrary value
   logic clk_in = 1'b0, lclk = 1'b0, rst_n_in = 1'b0;
   logic prot = 1'b0, srst = 1'b0;
   wire sclk, cs_n, mosi, miso, miso_oe, pend, latch, sleep, stby;
   int failures = 0, compares = 0, cyc = 0;
   logic [63:0] rx;

   // Unrelated core and link clocks
   always #12.5 clk_in = ~clk_in;
   always #3 lclk = ~lclk;

   fepic_top #(.ERASE_CYCLES(200), .MAKER_CODE(MAKER), .DEVICE_CODE(DEV),
      .MEM_TYPE(MEM), .CAPACITY(CAP)) fepic_top_i (.clk_in(clk_in),
      .rst_n_in(rst_n_in), .ce_in(1'b1), .sclk_in(sclk), .cs_n_in(cs_n),
      .serial_in(mosi), .serial_out_out(miso), .serial_out_oe_out(miso_oe),
      .any_block_protected_in(prot), .soft_reset_in(srst),
      .operation_pending_flag_out(pend), .write_unlock_latch_out(latch),
      .deep_sleep_out(sleep), .standby_out(stby));

   fepic_host_model fepic_host_model_i (.lclk_in(lclk), .sclk_out(sclk),
      .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso),
      .miso_oe_in(miso_oe));

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   task automatic ticks(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   // Frame then a gap long enough for the core to act
   task automatic cmd(input logic [63:0] tx, input int n);
      fepic_host_model_i.xfer(tx, n, rx);
      ticks(5);
   endtask

   task automatic conclude();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic check_reset();
      `CHK("pend", 1'b0, pend);
      `CHK("latch", 1'b0, latch);
      `CHK("sleep", 1'b0, sleep);
      `CHK("standby", 1'b1, stby);
   endtask

   task automatic id_reads();
      cmd({8'h9f, 24'h0}, 32);
      `CHK("std id", {MAKER, MEM, CAP}, rx[23:0]);
      cmd({8'h90, 24'h0, 16'h0}, 48);
      `CHK("id addr0", {MAKER, DEV}, rx[15:0]);
      cmd({8'h90, 24'h1, 16'h0}, 48);
      `CHK("id addr1", {DEV, MAKER}, rx[15:0]);
      cmd({8'hab, 24'h0, 16'h0}, 48);
      `CHK("wake id", {DEV, DEV}, rx[15:0]);
      fepic_host_model_i.xfer({8'h9f, 8'h0}, 16, rx);
      `CHK("cut on", 1'b1, fepic_host_model_i.oe_seen);
      `CHK("cut id", MAKER, rx[7:0]);
      #1;
      `CHK("cut oe", 1'b0, miso_oe);
      ticks(5);
      `CHK("cut standby", 1'b1, stby);
   endtask

   task automatic erase_refusals();
      cmd(64'hc7, 8);
      `CHK("no unlock", 1'b0, pend);
      cmd(64'h06, 8);
      `CHK("unlock", 1'b1, latch);
      cmd({8'hc7, 1'b0}, 9);
      `CHK("nine bits", 1'b0, pend);
      prot = 1'b1;
      cmd(64'hc7, 8);
      `CHK("protected", 1'b0, pend);
      prot = 1'b0;
   endtask

   task automatic erase_run(input logic [7:0] op);
      int n;
      cmd(64'h06, 8);
      cmd({56'h0, op}, 8);
      `CHK("erasing", 1'b1, pend);
      `CHK("latch clr", 1'b0, latch);
      cmd({8'h9f, 24'h0}, 32);
      `CHK("std busy", 1'b0, fepic_host_model_i.oe_seen);
      cmd({8'hab, 32'h0}, 40);
      `CHK("wake busy", 1'b0, fepic_host_model_i.oe_seen);
      cmd(64'hb9, 8);
      `CHK("still busy", 1'b1, pend);
      n = 0;
      while (pend === 1'b1 && n < 400)
      begin
         ticks(1);
         n++;
      end
      `CHK("erase done", 1'b0, pend);
      `CHK("no sleep", 1'b0, sleep);
   endtask

   task automatic sleep_tests();
      cmd({8'hb9, 1'b0}, 9);
      ticks(125);
      `CHK("sleep nine", 1'b0, sleep);
      cmd(64'hb9, 8);
      `CHK("entry wait", 1'b0, sleep);
      ticks(125);
      `CHK("asleep", 1'b1, sleep);
      cmd(64'h06, 8);
      `CHK("sleep lock", 1'b0, latch);
      cmd(64'hab, 8);
      ticks(110);
      `CHK("wake delay", 1'b1, sleep);
      ticks(15);
      `CHK("awake", 1'b0, sleep);
      cmd(64'hb9, 8);
      ticks(125);
      srst = 1'b1;
      ticks(1);
      srst = 1'b0;
      ticks(5);
      `CHK("soft reset", 1'b0, sleep);
      cmd(64'hb9, 8);
      ticks(125);
      cmd({8'hab, 32'h0}, 40);
      `CHK("sleep id", DEV, rx[7:0]);
      ticks(50);
      `CHK("second wait", 1'b1, sleep);
      ticks(25);
      `CHK("second done", 1'b0, sleep);
   endtask

   // -------------------------------------------------------------
   // Main sequence and hang guard
   // -------------------------------------------------------------
   // Host avoids the standard identity read while asleep
   initial
   begin
      ticks(20);
      rst_n_in = 1'b1;
      ticks(4);
      check_reset();
      id_reads();
      erase_refusals();
      erase_run(8'hc7);
      erase_run(8'h60);
      sleep_tests();
      conclude();
   end

   // Cycle ceiling far above the expected run length
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         conclude();
      end
   end
endmodule // tb
